// >>> rtl/twep_pkg.sv
package twep_pkg;

    // array geometry
    localparam int MEM_WORDS = 256;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int SLAVE_W   = 7;
    localparam int ROW_LSB   = 3;
    localparam int PAGE_W    = 3;
    localparam int BUF_DEPTH = 8;

    // write burst limits
    localparam logic [3:0] MULTI_MAX = 4'h4;
    localparam logic [3:0] PAGE_MAX  = 4'h8;

    // bit counter marks within one nine-clock byte slot
    localparam logic [3:0] BIT_ZERO     = 4'h0;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE = 4'h9;

    // direction bit encoding
    localparam logic RW_READ = 1'b1;

    // self-timed programming time
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PROG_TIME_MS    = 10;
    localparam int NS_PER_MS       = 1000000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_DEVADDR  = 6'h02,
        ST_WORDADDR = 6'h04,
        ST_WDATA    = 6'h08,
        ST_RDATA    = 6'h10,
        ST_PROG     = 6'h20
    } twep_state_t;

    // one prefetched read word with its location
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } twep_rd_t;

    // sampled pin pair
    typedef struct packed {
        logic scl;
        logic sda;
    } twep_bus_t;

endpackage : twep_pkg

// >>> rtl/twep_slave.sv
// Behaviour
// RULE_01 - hold 256 bytes, addressed by an 8-bit word address
// RULE_02 - transfer opens with START, address byte, direction bit, then slave acknowledge
// RULE_03 - multibyte mode takes up to four bytes, one programming cycle
// RULE_04 - page mode takes two to eight bytes, one programming cycle
// RULE_05 - current read returns byte after the last accessed location
// RULE_06 - random read returns byte at the word address just supplied
// RULE_07 - sequential read continues while master acknowledges and sends no STOP
// RULE_08 - programming cycle ends within ten milliseconds
// RULE_09 - multibyte write across two rows may take twice as long
// RULE_10 - master starts transfers and makes the serial clock
// RULE_11 - data line only pulled low or released, never driven high
// RULE_12 - select pins give the three low slave address bits
// RULE_13 - mode pin sets write limit of four or eight bytes
// RULE_14 - data change while clock high is START or STOP
// RULE_15 - START is data falling with clock high; no START, no response
// RULE_16 - STOP ends communication and enters standby
// RULE_17 - receiver pulls data low on ninth clock to acknowledge
// RULE_18 - incoming data sampled on rising serial clock
// RULE_19 - address sent msb first: 4-bit type code then 3 select bits
// RULE_20 - last address bit one means read, zero means write
// RULE_21 - only a matching device acknowledges and performs the operation
// RULE_22 - mode pin low selects page mode, else byte or multibyte
// RULE_23 - during programming ignore the bus and never acknowledge
// RULE_24 - page write increments only the low three address bits
// RULE_25 - no acknowledge after a read byte stops sending, back to receiver
`timescale 1ns/10ps
`default_nettype none

module twep_slave
    import twep_pkg::*;
#(
    parameter int         PROG_CYCLES = PROG_CYCLES_DEF,
    parameter logic [3:0] DEV_TYPE    = 4'h6 // arbitrary value
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe,
    // straps
    input  wire logic [2:0] device_select_pins,
    input  wire logic       wr_mode_sel,
    // status
    output var  logic       standby_o,
    output var  logic       prog_busy_o
);

    localparam int CNT_W = $clog2(2 * PROG_CYCLES + 1);

    twep_state_t       state_r;
    twep_bus_t         bus_q_r;
    logic [3:0]        bitcnt_r;
    logic [7:0]        shift_r;
    logic [7:0]        tx_r;
    logic              sda_oe_r;
    logic [7:0]        ptr_r;
    logic [7:0]        fetch_r;
    logic [7:0]        mem_r   [MEM_WORDS];
    logic [7:0]        wdata_r [BUF_DEPTH];
    logic [7:0]        waddr_r [BUF_DEPTH];
    logic [BUF_DEPTH-1:0] wvalid_r;
    logic [3:0]        wcount_r;
    logic [CNT_W-1:0]  prog_cnt_r;
    twep_rd_t          fifo_r  [2];
    logic              fifo_wp_r, fifo_rp_r;
    logic [1:0]        fifo_cnt_r;
    logic              standby_r, busy_r;

    logic              start_det, stop_det, scl_rise, scl_fall;
    logic              match, page_mode, accept, crosses;
    logic              wordaddr_done, data_done, enter_tx, prog_enter, prog_done, flush;
    logic              fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic [2:0]        widx, wlast;
    twep_rd_t          fifo_head;

    // true for states in which the device is receiving bytes
    function automatic logic is_rx(input twep_state_t s);
        is_rx = (s == ST_DEVADDR) || (s == ST_WORDADDR) || (s == ST_WDATA);
    endfunction : is_rx

    // pin history; edges only mean anything because the master owns scl
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            bus_q_r <= '{scl: 1'b1, sda: 1'b1};
        else
            bus_q_r <= '{scl: scl_i, sda: sda_i};
    end

    // bus events, all seen against the previous sample
    assign start_det = bus_q_r.scl && scl_i && bus_q_r.sda && !sda_i;   // see RULE_14 see RULE_15
    assign stop_det  = bus_q_r.scl && scl_i && !bus_q_r.sda && sda_i;   // see RULE_14 see RULE_16
    assign scl_rise  = scl_i && !bus_q_r.scl;                           // see RULE_10
    assign scl_fall  = !scl_i && bus_q_r.scl;

    // type code in the top nibble, straps below, direction in bit 0
    assign match = (shift_r[7:1] == {DEV_TYPE, device_select_pins});   // see RULE_12 see RULE_19 see RULE_21

    // mode pin grounded selects page writing
    assign page_mode = !wr_mode_sel;                                    // see RULE_22
    // multibyte stops acknowledging past its limit; page mode rolls over instead
    assign accept = page_mode || (wcount_r < MULTI_MAX);                // see RULE_13 see RULE_03

    // byte slot completion strobes, taken at the fall ending the ack clock
    assign wordaddr_done = scl_fall && (bitcnt_r == BIT_ACK_DONE) && (state_r == ST_WORDADDR);
    assign data_done     = scl_fall && (bitcnt_r == BIT_ACK_DONE) && (state_r == ST_WDATA) && accept;
    assign enter_tx      = scl_fall && (bitcnt_r == BIT_ACK_DONE)
                         && (((state_r == ST_DEVADDR) && (shift_r[0] == RW_READ)) || (state_r == ST_RDATA));
    assign prog_enter    = stop_det && (state_r == ST_WDATA) && (wcount_r != BIT_ZERO);
    assign prog_done     = (state_r == ST_PROG) && (prog_cnt_r == '0);
    assign flush         = (start_det && (state_r != ST_PROG)) || wordaddr_done;

    // main protocol sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r  <= ST_IDLE;
            bitcnt_r <= BIT_ZERO;
            shift_r  <= 8'h00;
            tx_r     <= 8'h00;
            sda_oe_r <= 1'b0;
        end
        else if (state_r == ST_PROG)
        begin
            // deaf until the cell programming finishes
            sda_oe_r <= 1'b0;                                           // see RULE_23
            if (prog_done)
                state_r <= ST_IDLE;
        end
        else if (start_det)
        begin
            state_r  <= ST_DEVADDR;                                     // see RULE_02 see RULE_15
            bitcnt_r <= BIT_ZERO;
            sda_oe_r <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r  <= prog_enter ? ST_PROG : ST_IDLE;                 // see RULE_16
            sda_oe_r <= 1'b0;
        end
        else if (state_r != ST_IDLE)
        begin
            if (scl_rise)
            begin
                if (bitcnt_r < BIT_ACK_SLOT)
                begin
                    shift_r  <= {shift_r[6:0], sda_i};                  // see RULE_18 see RULE_19
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                else if ((bitcnt_r == BIT_ACK_DONE) && (state_r == ST_RDATA) && sda_i)
                    state_r <= ST_IDLE;                                 // see RULE_25
            end
            else if (scl_fall)
            begin
                if (bitcnt_r == BIT_ACK_SLOT)
                begin
                    bitcnt_r <= BIT_ACK_DONE;
                    if (state_r == ST_RDATA)
                        sda_oe_r <= 1'b0;                               // see RULE_17
                    else if ((state_r == ST_DEVADDR) && !match)
                        state_r <= ST_IDLE;                             // see RULE_21
                    else
                        sda_oe_r <= (state_r != ST_WDATA) || accept;    // see RULE_17 see RULE_02
                end
                else if (bitcnt_r == BIT_ACK_DONE)
                begin
                    bitcnt_r <= BIT_ZERO;
                    if (state_r == ST_DEVADDR)
                        state_r <= (shift_r[0] == RW_READ) ? ST_RDATA : ST_WORDADDR; // see RULE_20
                    else if (state_r == ST_WORDADDR)
                        state_r <= ST_WDATA;
                    if (enter_tx)
                    begin
                        // first bit goes out on the same fall that ends the ack
                        tx_r     <= {fifo_head.data[6:0], 1'b0};
                        sda_oe_r <= !fifo_head.data[7];                 // see RULE_11 see RULE_07
                    end
                    else
                        sda_oe_r <= 1'b0;
                end
                else if (state_r == ST_RDATA)
                begin
                    sda_oe_r <= !tx_r[7];                               // see RULE_11
                    tx_r     <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    // address pointer: last location touched, plus one
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ptr_r <= 8'h00;
        else if (wordaddr_done)
            ptr_r <= shift_r;                                           // see RULE_06
        else if (data_done && page_mode)
            ptr_r <= {ptr_r[7:ROW_LSB], ptr_r[PAGE_W-1:0] + 3'h1};      // see RULE_24
        else if (data_done)
            ptr_r <= ptr_r + 8'h01;
        else if (enter_tx)
            ptr_r <= fifo_head.addr + 8'h01;                            // see RULE_05
    end

    // write staging: page mode indexes by low address bits so rollover overwrites
    assign widx  = page_mode ? ptr_r[PAGE_W-1:0] : wcount_r[2:0];
    assign wlast = wcount_r[2:0] - 3'h1;

    always_ff @(posedge clk)
    begin
        if (!rst_b || (start_det && (state_r != ST_PROG)))
        begin
            wvalid_r <= '0;
            wcount_r <= BIT_ZERO;
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                wdata_r[i] <= 8'h00;
                waddr_r[i] <= 8'h00;
            end
        end
        else if (data_done)
        begin
            wdata_r[widx]  <= shift_r;                                  // see RULE_04 see RULE_03
            waddr_r[widx]  <= ptr_r;
            wvalid_r[widx] <= 1'b1;
            if (wcount_r < PAGE_MAX)
                wcount_r <= wcount_r + 4'h1;
        end
    end

    // multibyte bursts are not row-bound, so the last word may sit in the next row
    assign crosses = !page_mode && (waddr_r[0][7:ROW_LSB] != waddr_r[wlast][7:ROW_LSB]);

    // self-timed programming counter; length fixed when the STOP arrives
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            prog_cnt_r <= '0;
        else if (prog_enter)
            prog_cnt_r <= crosses ? CNT_W'(2 * PROG_CYCLES - 1)         // see RULE_09
                                  : CNT_W'(PROG_CYCLES - 1);            // see RULE_08
        else if ((state_r == ST_PROG) && (prog_cnt_r != '0))
            prog_cnt_r <= prog_cnt_r - CNT_W'(1);
    end

    // array commit: every staged word lands in the one cycle
    always_ff @(posedge clk)
    begin
        if (prog_enter)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                if (wvalid_r[i])
                    mem_r[waddr_r[i]] <= wdata_r[i];                    // see RULE_01
            end
        end
    end

    // read prefetch into a two-entry buffer; the shifter drains it per byte
    assign fifo_in_valid  = (state_r != ST_PROG) && !flush;
    assign fifo_in_ready  = (fifo_cnt_r != 2'h2);
    assign fifo_out_valid = (fifo_cnt_r != 2'h0);
    assign fifo_head      = fifo_r[fifo_rp_r];

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            fetch_r <= 8'h00;
        else if (start_det && (state_r != ST_PROG))
            fetch_r <= ptr_r;                                           // see RULE_05
        else if (wordaddr_done)
            fetch_r <= shift_r;                                         // see RULE_06
        else if (fifo_in_valid && fifo_in_ready)
            fetch_r <= fetch_r + 8'h01;                                 // see RULE_07
    end

    // a stalled shifter leaves the buffer full, which stalls the fetch above
    always_ff @(posedge clk)
    begin
        if (!rst_b || flush)
        begin
            fifo_wp_r  <= 1'b0;
            fifo_rp_r  <= 1'b0;
            fifo_cnt_r <= 2'h0;
            for (int i = 0; i < 2; i++)
                fifo_r[i] <= '0;
        end
        else
        begin
            if (fifo_in_valid && fifo_in_ready)
            begin
                fifo_r[fifo_wp_r] <= '{addr: fetch_r, data: mem_r[fetch_r]};
                fifo_wp_r         <= !fifo_wp_r;
            end
            if (enter_tx && fifo_out_valid)
                fifo_rp_r <= !fifo_rp_r;
            fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_in_valid && fifo_in_ready}
                                     - {1'b0, enter_tx && fifo_out_valid};
        end
    end

    // status flags lag the state by one clock
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            standby_r <= 1'b1;
            busy_r    <= 1'b0;
        end
        else
        begin
            standby_r <= (state_r == ST_IDLE);                          // see RULE_16
            busy_r    <= (state_r == ST_PROG);                          // see RULE_23
        end
    end

    assign sda_o       = 1'b0;   // open drain: only the enable ever moves
    assign sda_oe      = sda_oe_r;
    assign standby_o   = standby_r;
    assign prog_busy_o = busy_r;

    a_sda_open_drain: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_11 see RULE_14
        !sda_o && (!$rose(sda_oe_r) || !bus_q_r.scl))
        else $error("data line driven high or pulled with clock high");
    a_busy_no_ack: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_23
        (state_r == ST_PROG) && $past(state_r == ST_PROG) |-> !sda_oe_r)
        else $error("acknowledge during programming");
    a_start_restarts: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_15
        start_det && (state_r != ST_PROG) |=> (state_r == ST_DEVADDR) && (bitcnt_r == BIT_ZERO))
        else $error("start not taken");
    a_stop_releases: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_16
        stop_det && (state_r != ST_PROG) |=> !sda_oe_r && ((state_r == ST_IDLE) || (state_r == ST_PROG))
                                             ##1 standby_r == (state_r == ST_IDLE))
        else $error("stop did not end the transfer");
    a_addr_mismatch: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_21
        (state_r == ST_DEVADDR) && scl_fall && (bitcnt_r == BIT_ACK_SLOT) && !match && !start_det && !stop_det
        |=> (state_r == ST_IDLE) && !sda_oe_r)
        else $error("foreign address acknowledged");
    a_ack_word_addr: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_17
        (state_r == ST_WORDADDR) && scl_fall && (bitcnt_r == BIT_ACK_SLOT) && !start_det && !stop_det
        |=> sda_oe_r && (bitcnt_r == BIT_ACK_DONE))
        else $error("word address not acknowledged");
    a_nack_ends_read: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_25
        (state_r == ST_RDATA) && scl_rise && (bitcnt_r == BIT_ACK_DONE) && sda_i && !start_det && !stop_det
        |=> (state_r == ST_IDLE) && !sda_oe_r)
        else $error("read continued after no acknowledge");
    a_page_row_kept: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_24
        data_done && page_mode |=> (ptr_r[7:ROW_LSB] == $past(ptr_r[7:ROW_LSB]))
                                && (ptr_r[PAGE_W-1:0] == $past(ptr_r[PAGE_W-1:0]) + 3'h1))
        else $error("page address left its row");
    a_prog_bounded: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_08
        prog_enter |=> (state_r == ST_PROG) && (prog_cnt_r < CNT_W'(2 * PROG_CYCLES)))
        else $error("programming time out of range");
    a_read_word_ready: assert property (@(posedge clk) disable iff (!rst_b)  // see RULE_07
        enter_tx |-> fifo_out_valid)
        else $error("read buffer empty at byte start");

endmodule : twep_slave

`default_nettype wire

// >>> dv/twep_master.sv
`timescale 1ns/10ps
`default_nettype none

module twep_master
    import twep_pkg::*;
(
    // clock
    input  wire logic clk,
    // two-wire bus
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    // scl low stays at least four clk, so the read prefetch can refill
    localparam int HALF = 8;

    // idle bus: both lines released
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // all changes land just after a clk edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // data falls while scl is high; works as a repeated start too
    task automatic start_c();
        sda_low = 1'b0;
        tick(HALF);
        scl = 1'b1; // master makes every clock
        tick(HALF);
        sda_low = 1'b1; // start condition
        tick(HALF);
        scl = 1'b0;
        tick(HALF / 2);
    endtask : start_c

    // data rises while scl is high
    task automatic stop_c();
        sda_low = 1'b1;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0; // stop condition
        tick(HALF);
    endtask : stop_c

    // one clock: data set while scl low, held across the rising edge
    task automatic bit_c(input logic b, output logic s);
        sda_low = ~b; // changes only with scl low
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF / 2);
        s = sda;
        tick(HALF / 2);
        scl = 1'b0;
        tick(HALF / 2);
    endtask : bit_c

    // msb first, then release for the slave's acknowledge
    task automatic tx_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_c(b[i], s);
        bit_c(1'b1, s); // line released on the ninth clock
        ack = ~s;
    endtask : tx_byte

    // line released for eight bits, then ack or nack
    task automatic rx_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_c(1'b1, d[i]);
        bit_c(~ack_it, s); // nack ends a read
    endtask : rx_byte

endmodule : twep_master

`default_nettype wire

// >>> dv/twowire_eeprom_slave_port_test.sv
`timescale 1ns/10ps
`default_nettype none

module twowire_eeprom_slave_port_test
    import twep_pkg::*;
;
    localparam int         PROG     = 200;  // short busy time keeps the run brief
    localparam logic [3:0] DEV_CODE = 4'h5; // arbitrary value
    localparam logic [2:0] SEL      = 3'h5;
    localparam logic [7:0] DEV_W    = {DEV_CODE, SEL, 1'b0};
    localparam logic [7:0] DEV_R    = {DEV_CODE, SEL, 1'b1};

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } twep_row_t;

    logic       clk;
    logic       rst_b;
    logic       scl;
    logic       sda_low;
    wire logic  sda;
    logic       sda_o;
    logic       sda_oe;
    logic [2:0] sel_pins;
    logic       wr_mode_sel;
    logic       standby_o;
    logic       prog_busy_o;
    int         n_fail;
    int         comparisons;
    twep_row_t  rows [4] = '{'{8'h00, 8'ha5}, '{8'hff, 8'h5a}, '{8'h37, 8'h00}, '{8'h80, 8'hff}};
    logic [7:0] bad  [4] = '{{DEV_CODE, 3'h4, 1'b0}, {DEV_CODE, 3'h1, 1'b0}, {4'h3, SEL, 1'b0},
                             {4'hd, SEL, 1'b1}};

    // wired-and with pull-up: a released line reads high
    assign sda = ~(sda_low | (sda_oe & ~sda_o));

    twep_master master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    twep_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV_CODE)) uut (
        .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .device_select_pins(sel_pins), .wr_mode_sel(wr_mode_sel), .standby_o(standby_o),
        .prog_busy_o(prog_busy_o));

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic wbyte(input logic [7:0] b, input logic exp_ack);
        logic ack;
        master.tx_byte(b, ack);
        chk({7'h0, ack}, {7'h0, exp_ack}); // acknowledge on the ninth clock
    endtask : wbyte

    // start, address, word address, data bytes, stop
    task automatic write_seq(input logic [7:0] addr, input logic [7:0] d[$], input int n_ack);
        master.start_c();
        wbyte(DEV_W, 1'b1);
        chk({7'h0, standby_o}, 8'h00); // awake while addressed
        wbyte(addr, 1'b1);
        foreach (d[i])
            wbyte(d[i], i < n_ack); // bytes past the limit refused
        master.stop_c();
    endtask : write_seq

    // a negative address reads from the held pointer
    task automatic read_seq(input int addr, input logic [7:0] exp[$]);
        logic [7:0] got;
        if (addr >= 0)
        begin
            master.start_c();
            wbyte(DEV_W, 1'b1);
            wbyte(addr[7:0], 1'b1);
        end
        master.start_c();
        wbyte(DEV_R, 1'b1); // direction bit one reads
        foreach (exp[i])
        begin
            master.rx_byte(i < exp.size() - 1, got);
            chk(got, exp[i]); // consecutive bytes while acked
        end
        master.stop_c();
    endtask : read_seq

    // busy must end inside the limit, then the part sleeps
    task automatic wait_idle(input int limit);
        int n;
        n = 0;
        chk({7'h0, prog_busy_o}, 8'h01); // stop starts programming
        while (prog_busy_o !== 1'b0 && n <= limit)
        begin
            tick(1);
            n++;
        end
        chk({7'h0, n <= limit}, 8'h01);
        chk({7'h0, n >= PROG - 16}, 8'h01); // busy held at least PROG - 16 clocks, the same floor when rows were crossed
        tick(2);
        chk({7'h0, standby_o}, 8'h01);
    endtask : wait_idle

    // main sequence
    initial
    begin
        n_fail      = 0;
        comparisons = 0;
        rst_b       = 1'b0;
        sel_pins    = SEL;
        wr_mode_sel = 1'b1;
        tick(5);
        chk({5'h0, sda_oe, standby_o, prog_busy_o}, 8'h02); // reset values
        rst_b = 1'b1;
        tick(2);
        // ordinary cases: byte write then random read back
        foreach (rows[i])
        begin
            write_seq(rows[i].addr, {rows[i].data}, 1);
            wait_idle(PROG + 4);
            read_seq(rows[i].addr, {rows[i].data});
        end
        // foreign address: silent, and later bytes without a start stay unanswered
        foreach (bad[i])
        begin
            master.start_c();
            wbyte(bad[i], 1'b0);
            wbyte(DEV_W, 1'b0);
            master.stop_c();
        end
        // other strap setting: the same address byte is now answered
        sel_pins = 3'h4;
        master.start_c();
        wbyte(bad[0], 1'b1);
        master.stop_c();
        sel_pins = SEL;
        // multibyte across a row boundary; fifth byte refused
        write_seq(8'h06, {8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 4);
        master.start_c();
        wbyte(DEV_W, 1'b0); // deaf while programming
        master.stop_c();
        wait_idle(2 * PROG + 4);
        read_seq(8'h06, {8'h11, 8'h22, 8'h33}); // nack ends it
        read_seq(-1, {8'h44});
        // page mode: nine bytes wrap inside the row and overwrite the first
        wr_mode_sel = 1'b0;
        write_seq(8'h2e, {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8}, 9);
        wait_idle(PROG + 4);
        read_seq(8'h28, {8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hd1});
        // reset in mid transfer drops the exchange
        master.start_c();
        wbyte(DEV_W, 1'b1);
        rst_b = 1'b0;
        tick(5);
        chk({5'h0, sda_oe, standby_o, prog_busy_o}, 8'h02); // reset values again
        rst_b = 1'b1;
        master.stop_c();
        read_seq(8'h2f, {8'hd1});
        chk({7'h0, sda_o}, 8'h00); // only ever pulls low
        stop_test();
    end

    // watchdog: the whole sequence needs well under this span
    initial
    begin
        tick(40000);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

endmodule : twowire_eeprom_slave_port_test

`default_nettype wire
